// ---- src/tfr_result_fifo.sv ----
// Overview of operation
// - With touch still present after a scan, idle timed until the interval expires.
// - No touch at scan end: return to touch-detect idle, wait for new touch.
// - Only initial, release, or aperture-qualified midpress blocks enter the store.
// - Interrupt rises on a logged block and stays while blocks remain in the store.
// - Reading with nothing stored returns a word tagged 11; host discards it.
// - Leaving power-down runs the pull-up settle sequence before sampling touch.
// - Mode change between normal modes clears interrupt and reruns settle sequence.
// - Store holds sixteen complete blocks, 1024 bits.
// - Blocks hold two, three or four 16-bit words per scan type.
// - When full, new qualifying blocks are dropped and old contents kept.
// - Overflow flag in status register 0x00 sets on data loss.
// - Any write to mode register 0x0B empties the store and drops the interrupt.
// - Store emptied on switching between autonomous and direct operation.
// - Words leave X, Y, Z1, Z2 order, MSB byte first, blocks in order.
// - A block commits whole, interrupt only after the full tagged block.
// - Word is position [15:4], measurement tag [3:2], event tag [1:0].
// - 8-bit results sit in [15:8]; low nibble zero unless averaging.
// - Every word of a block carries the event tag from the scan end.
// - Readback start moves a whole block to holding and frees its slot.
// - Interrupt clears when the newest block loads, not while others remain.
// - Measurement tag: X 00, Y 01, Z1 10, Z2 11.
// - Event tag: initial 00, midpress 01, release 10, end of data 11.
`timescale 1ns/1ps
`default_nettype none
module tfr_result_fifo #(
   parameter int INTERVAL_CYC = tfr_pkg::TFR_INTERVAL_CYC,
   parameter int BLOCKS = tfr_pkg::TFR_BLOCKS
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic ce,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Panel and measurement engine
   input wire logic touch_pin,
   input wire logic scan_done,
   input wire tfr_pkg::tfr_scan_t scan_result,
   output logic scan_start,
   output logic panel_drive_en,
   // Block readback
   input wire logic blk_req,
   input wire logic link_clk,
   input wire logic link_sel_n,
   output logic [7:0] rd_byte,
   output logic rd_byte_stb,
   output logic blk_busy,
   // Interrupt pin
   output logic touch_irq_out
);
   import tfr_pkg::*;

   localparam int WORDS = BLOCKS * TFR_WORDS_PER_SLOT;
   localparam int PW = $clog2(BLOCKS);
   localparam int SETTLE_W = $clog2(TFR_SETTLE_CYC + 1);
   localparam int IVL_W = $clog2(INTERVAL_CYC + 1);

   typedef enum logic [2:0] {ST_POWER_DOWN_MODE, ST_SETTLE, ST_DIRECT, ST_TDM, ST_SCAN, ST_LPM} tfr_state_t;

   // Words in a block for the configured scan type
   function automatic logic [2:0] block_words(input logic [1:0] st);
      case (st)
         TFR_SC_XYZ1: block_words = 3'h3;
         TFR_SC_XYZ1Z2: block_words = 3'h4;
         default: block_words = 3'h2;
      endcase
   endfunction

   // ==========================================================
   // Pin synchronisers
   logic touch_s1_reg, touch_s2_reg;
   logic lclk_s1_reg, lclk_s2_reg, lclk_d_reg;
   logic lsel_s1_reg, lsel_s2_reg;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         touch_s1_reg <= 1'b0;
         touch_s2_reg <= 1'b0;
         lclk_s1_reg <= 1'b0;
         lclk_s2_reg <= 1'b0;
         lclk_d_reg <= 1'b0;
         lsel_s1_reg <= 1'b1;
         lsel_s2_reg <= 1'b1;
      end else if (ce) begin
         touch_s1_reg <= touch_pin;
         touch_s2_reg <= touch_s1_reg;
         lclk_s1_reg <= link_clk;
         lclk_s2_reg <= lclk_s1_reg;
         lclk_d_reg <= lclk_s2_reg;
         lsel_s1_reg <= link_sel_n;
         lsel_s2_reg <= lsel_s1_reg;
      end
   end
   logic link_rise;
   assign link_rise = lclk_s2_reg & ~lclk_d_reg & ~lsel_s2_reg;

   // ==========================================================
   // Mode register
   logic [7:0] mode_reg;
   logic mode_wr, mode_change;
   tfr_op_t op_now, op_new;
   assign mode_wr = reg_wr && reg_addr == TFR_ADDR_MODE;
   assign op_now = tfr_op_t'(mode_reg[TFR_MD_MODE_LSB +: 2]);
   assign op_new = tfr_op_t'(reg_wdata[TFR_MD_MODE_LSB +: 2]);
   assign mode_change = mode_wr && op_new != op_now;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mode_reg <= TFR_MODE_RESET;
      end else if (ce && mode_wr) begin
         mode_reg <= reg_wdata;
      end
   end

   // ==========================================================
   // Scan sequencer
   tfr_state_t state_reg;
   logic [SETTLE_W-1:0] settle_reg;
   logic [IVL_W-1:0] ivl_reg;
   logic auto_on;
   assign auto_on = op_now == TFR_OP_AUTO;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_POWER_DOWN_MODE;
         settle_reg <= '0;
         ivl_reg <= '0;
      end else if (ce) begin
         if (mode_change) begin
            // Panel capacitance from the previous setup could look like a touch
            state_reg <= op_new == TFR_OP_POWER_DOWN_MODE ? ST_POWER_DOWN_MODE : ST_SETTLE;
            settle_reg <= SETTLE_W'(TFR_SETTLE_CYC);
         end else begin
            case (state_reg)
               ST_POWER_DOWN_MODE: state_reg <= ST_POWER_DOWN_MODE;
               ST_SETTLE: begin
                  if (settle_reg > SETTLE_W'(1)) begin
                     settle_reg <= settle_reg - SETTLE_W'(1);
                  end else begin
                     state_reg <= auto_on ? ST_TDM : ST_DIRECT;
                  end
               end
               ST_DIRECT: state_reg <= ST_DIRECT;
               ST_TDM: begin
                  if (touch_s2_reg) begin
                     state_reg <= ST_SCAN;
                  end
               end
               ST_SCAN: begin
                  if (scan_done) begin
                     state_reg <= scan_result.touch_end ? ST_LPM : ST_TDM;
                     ivl_reg <= IVL_W'(INTERVAL_CYC);
                  end
               end
               ST_LPM: begin
                  if (ivl_reg > IVL_W'(1)) begin
                     ivl_reg <= ivl_reg - IVL_W'(1);
                  end else begin
                     state_reg <= ST_SCAN;
                  end
               end
               default: state_reg <= ST_POWER_DOWN_MODE;
            endcase
         end
      end
   end
   assign scan_start = ce && !mode_change && ((state_reg == ST_TDM && touch_s2_reg) ||
      (state_reg == ST_LPM && ivl_reg <= IVL_W'(1)));
   assign panel_drive_en = state_reg != ST_POWER_DOWN_MODE;

   // ==========================================================
   // Tagging and qualification
   logic [1:0] event_tag;
   logic qualify;
   logic [2:0] nwords;
   tfr_word_t [3:0] new_words;
   always_comb begin
      if (!scan_result.touch_end) begin
         event_tag = TFR_ET_RELEASE;
      end else if (scan_result.first) begin
         event_tag = TFR_ET_INITIAL;
      end else begin
         event_tag = TFR_ET_MID;
      end
      qualify = event_tag != TFR_ET_MID || scan_result.aperture_met;
      nwords = block_words(mode_reg[TFR_MD_SCAN_LSB +: 2]);
      for (int k = 0; k < 4; k++) begin
         new_words[k].pos = scan_result.pos[k];
         if (mode_reg[TFR_MD_RES8_BIT] && !mode_reg[TFR_MD_AVG_BIT]) begin
            new_words[k].pos[3:0] = 4'h0;
         end
         new_words[k].mtag = 2'(k);
         new_words[k].event_tag = event_tag;
      end
   end

   // ==========================================================
   // Block store
   tfr_word_t mem_reg [WORDS];
   logic [2:0] len_reg [BLOCKS];
   logic [PW-1:0] wp_reg, rp_reg;
   logic [PW:0] count_reg;
   logic commit, full, load, hold_free;
   assign full = count_reg == (PW+1)'(BLOCKS);
   assign commit = ce && state_reg == ST_SCAN && scan_done && qualify && !full && !mode_wr;
   assign load = ce && blk_req && hold_free && !mode_wr;
   always_ff @(posedge sys_clk) begin
      if (commit) begin
         for (int k = 0; k < 4; k++) begin
            mem_reg[{wp_reg, 2'(k)}] <= new_words[k];
         end
         len_reg[wp_reg] <= nwords;
      end
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wp_reg <= '0;
         rp_reg <= '0;
         count_reg <= '0;
      end else if (ce) begin
         if (mode_wr) begin
            wp_reg <= '0;
            rp_reg <= '0;
            count_reg <= '0;
         end else begin
            if (commit) begin
               wp_reg <= wp_reg + PW'(1);
            end
            if (load && count_reg != '0) begin
               rp_reg <= rp_reg + PW'(1);
            end
            count_reg <= count_reg + (PW+1)'(commit) - (PW+1)'(load && count_reg != '0);
         end
      end
   end

   // ==========================================================
   // Overflow flag and interrupt, set wins over clear
   logic ovf_reg, irq_reg;
   logic last_load;
   assign last_load = load && count_reg == (PW+1)'(1);
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ovf_reg <= 1'b0;
      end else if (ce) begin
         if (state_reg == ST_SCAN && scan_done && qualify && full) begin
            ovf_reg <= 1'b1;
         end else if (mode_wr) begin
            ovf_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         irq_reg <= 1'b0;
      end else if (ce) begin
         if (commit) begin
            irq_reg <= 1'b1;
         end else if (mode_wr || last_load) begin
            irq_reg <= 1'b0;
         end
      end
   end
   assign touch_irq_out = irq_reg;

   // ==========================================================
   // Holding buffer, one whole block or one end-of-data word
   tfr_word_t [3:0] hold_reg;
   logic [2:0] hold_n_reg, hold_i_reg;
   logic push, push_rdy;
   assign hold_free = hold_i_reg == hold_n_reg;
   assign push = !hold_free;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         hold_reg <= '0;
         hold_n_reg <= '0;
         hold_i_reg <= '0;
      end else if (ce) begin
         if (load) begin
            hold_i_reg <= '0;
            if (count_reg != '0) begin
               for (int k = 0; k < 4; k++) begin
                  hold_reg[k] <= mem_reg[{rp_reg, 2'(k)}];
               end
               hold_n_reg <= len_reg[rp_reg];
            end else begin
               hold_reg[0] <= '{pos: 12'h000, mtag: 2'h0, event_tag: TFR_ET_EOF};
               hold_n_reg <= 3'h1;
            end
         end else if (push && push_rdy) begin
            hold_i_reg <= hold_i_reg + 3'h1;
         end
      end
   end

   // ==========================================================
   // Two-entry word buffer between holding and the serial shifter
   tfr_word_t buf_reg [2];
   logic [1:0] buf_cnt_reg;
   logic buf_rp_reg, buf_wp_reg;
   logic pop, pop_vld;
   assign push_rdy = buf_cnt_reg != 2'h2;
   assign pop_vld = buf_cnt_reg != 2'h0;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         buf_reg[0] <= '0;
         buf_reg[1] <= '0;
         buf_cnt_reg <= '0;
         buf_rp_reg <= 1'b0;
         buf_wp_reg <= 1'b0;
      end else if (ce) begin
         if (push && push_rdy) begin
            buf_reg[buf_wp_reg] <= hold_reg[hold_i_reg[1:0]];
            buf_wp_reg <= ~buf_wp_reg;
         end
         if (pop && pop_vld) begin
            buf_rp_reg <= ~buf_rp_reg;
         end
         buf_cnt_reg <= buf_cnt_reg + 2'(push && push_rdy) - 2'(pop && pop_vld);
      end
   end

   // ==========================================================
   // Serial byte shifter, one byte per link clock rise
   logic [7:0] lsb_reg;
   logic half_reg;
   // Stalls on an idle link so the word buffer truly fills
   assign pop = link_rise && !half_reg;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rd_byte <= 8'h00;
         rd_byte_stb <= 1'b0;
         lsb_reg <= 8'h00;
         half_reg <= 1'b0;
      end else if (ce) begin
         rd_byte_stb <= 1'b0;
         if (link_rise && half_reg) begin
            rd_byte <= lsb_reg;
            rd_byte_stb <= 1'b1;
            half_reg <= 1'b0;
         end else if (pop && pop_vld) begin
            rd_byte <= buf_reg[buf_rp_reg][15:8];
            lsb_reg <= buf_reg[buf_rp_reg][7:0];
            rd_byte_stb <= 1'b1;
            half_reg <= 1'b1;
         end
      end
   end
   // Host abandoning a block mid-way leaves words queued; they go out first on later link clocks, and no load starts until holding drains
   assign blk_busy = !hold_free || pop_vld || half_reg;

   // ==========================================================
   // Register reads
   logic [7:0] status;
   // Bit by bit, so no flag is lost to the width of a one-bit shift
   always_comb begin
      status = 8'h00;
      status[TFR_ST_OVF_BIT] = ovf_reg;
      status[TFR_ST_EMPTY_BIT] = count_reg == '0;
      status[TFR_ST_IRQ_BIT] = irq_reg;
      status[TFR_ST_TOUCH_BIT] = touch_s2_reg;
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (ce && reg_rd) begin
         case (reg_addr)
            TFR_ADDR_STATUS: reg_rdata <= status;
            TFR_ADDR_MODE: reg_rdata <= mode_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Checks
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   count_bound_a: assert property (count_reg <= (PW+1)'(BLOCKS)) else $error("block count over depth");
   irq_after_commit_a: assert property (commit |=> touch_irq_out) else $error("irq missing after commit");
   mode_clear_a: assert property (ce && mode_wr |=> count_reg == '0 && !touch_irq_out)
      else $error("mode write did not clear");
   irq_last_clear_a: assert property (last_load && !commit && !mode_wr |=> !touch_irq_out)
      else $error("irq held after last block load");
   irq_hold_a: assert property (load && count_reg > (PW+1)'(1) && !mode_wr |=> touch_irq_out)
      else $error("irq dropped with blocks left");
   eof_tag_a: assert property (load && count_reg == '0 |=> hold_reg[0].event_tag == TFR_ET_EOF && hold_n_reg == 3'h1)
      else $error("empty read not tagged end of data");
   full_drop_a: assert property (ce && full && scan_done && !mode_wr && !load |=> count_reg == (PW+1)'(BLOCKS))
      else $error("full store overwritten");
   ovf_set_a: assert property (ce && state_reg == ST_SCAN && scan_done && qualify && full |=> ovf_reg)
      else $error("overflow not flagged");
   settle_first_a: assert property (ce && mode_change && op_new != TFR_OP_POWER_DOWN_MODE |=> state_reg == ST_SETTLE)
      else $error("settle skipped on mode change");
   lpm_wait_a: assert property (ce && state_reg == ST_SCAN && scan_done && scan_result.touch_end && !mode_change
      |=> state_reg == ST_LPM [*2]) else $error("interval not waited");
endmodule
`default_nettype wire

// ---- shared/tfr_pkg.sv ----
`default_nettype none
package tfr_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] TFR_ADDR_STATUS = 8'h00;
   localparam logic [7:0] TFR_ADDR_MODE = 8'h0B;
   localparam int TFR_ST_OVF_BIT = 0;
   localparam int TFR_ST_EMPTY_BIT = 1;
   localparam int TFR_ST_IRQ_BIT = 2;
   localparam int TFR_ST_TOUCH_BIT = 3;
   localparam int TFR_MD_MODE_LSB = 0;
   localparam int TFR_MD_SCAN_LSB = 2;
   localparam int TFR_MD_RES8_BIT = 4;
   localparam int TFR_MD_AVG_BIT = 5;
   localparam logic [7:0] TFR_MODE_RESET = 8'h00;
   // ==========================================================
   // Store geometry
   localparam int TFR_BLOCKS = 16;
   localparam int TFR_WORDS_PER_SLOT = 4;
   localparam int TFR_BITS_TOTAL = 1024;
   // ==========================================================
   // Tags
   localparam logic [1:0] TFR_ET_INITIAL = 2'h0;
   localparam logic [1:0] TFR_ET_MID = 2'h1;
   localparam logic [1:0] TFR_ET_RELEASE = 2'h2;
   localparam logic [1:0] TFR_ET_EOF = 2'h3;
   // ==========================================================
   // Timing
   localparam int TFR_CLK_NS = 100;
   localparam int TFR_SETTLE_NS = 20000;
   localparam int TFR_SETTLE_CYC = (TFR_SETTLE_NS + TFR_CLK_NS - 1) / TFR_CLK_NS;
   localparam int TFR_INTERVAL_US = 5000;
   localparam int TFR_INTERVAL_CYC = TFR_INTERVAL_US * 1000 / TFR_CLK_NS;

   typedef enum logic [1:0] {TFR_OP_POWER_DOWN_MODE, TFR_OP_DIRECT, TFR_OP_AUTO, TFR_OP_RSVD} tfr_op_t;
   typedef enum logic [1:0] {TFR_SC_RSVD, TFR_SC_XY, TFR_SC_XYZ1, TFR_SC_XYZ1Z2} tfr_scan_type_t;

   // One finished scan from the measurement engine, positions in X,Y,Z1,Z2 order
   typedef struct packed {
      logic [3:0][11:0] pos;
      logic touch_end;
      logic first;
      logic aperture_met;
   } tfr_scan_t;

   typedef struct packed {
      logic [11:0] pos;
      logic [1:0] mtag;
      logic [1:0] event_tag;
   } tfr_word_t;
endpackage
`default_nettype wire

// ---- verification/tfr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tfr_host_model (
   // Clock
   input wire logic sys_clk,
   // Readback port of the device
   input wire logic [7:0] rd_byte,
   input wire logic rd_byte_stb,
   output logic blk_req,
   output logic link_clk,
   output logic link_sel_n
);
   // ==========================================================
   // Host side of one block readback
   logic [7:0] got [0:7];
   int got_n;

   initial begin
      blk_req = 1'b0;
      link_clk = 1'b0;
      link_sel_n = 1'b1;
   end

   // Link clock idles low between frames; 800 ns per byte
   task automatic read_block(input int n);
      int i;
      int k;
      got_n = 0;
      blk_req = 1'b1;
      @(posedge sys_clk);
      #1 blk_req = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 link_sel_n = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      for (i = 0; i < n; i++) begin
         link_clk = 1'b1;
         for (k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            #1;
            if (rd_byte_stb === 1'b1 && got_n < 8) begin
               got[got_n] = rd_byte;
               got_n++;
            end
            if (k == 3) begin
               link_clk = 1'b0;
            end
         end
      end
      link_sel_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tfr_pkg::*;
   localparam int INTERVAL = 20;
   logic sys_clk, reset, ce, reg_wr, reg_rd, touch_pin, st;
   logic scan_done = 1'b0;
   logic was_free = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_byte;
   tfr_scan_t scan_result = '0;
   logic scan_start, panel_drive_en, blk_req, link_clk, link_sel_n, rd_byte_stb, blk_busy, touch_irq_out;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int seed = 32'hbb39;
   int eng_cnt = 0;
   int ovf = 0;
   int nwords = 2;
   int res8 = 0;
   int starts = 0;
   // Reference store: words and block sizes
   logic [15:0] mq[$];
   int bq[$];

   tfr_result_fifo #(.INTERVAL_CYC(INTERVAL), .BLOCKS(TFR_BLOCKS)) tfr_result_fifo_inst (
      .sys_clk(sys_clk), .reset(reset), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .touch_pin(touch_pin),
      .scan_done(scan_done), .scan_result(scan_result), .scan_start(scan_start),
      .panel_drive_en(panel_drive_en), .blk_req(blk_req), .link_clk(link_clk), .link_sel_n(link_sel_n),
      .rd_byte(rd_byte), .rd_byte_stb(rd_byte_stb), .blk_busy(blk_busy), .touch_irq_out(touch_irq_out));

   tfr_host_model tfr_host_model_inst (
      .sys_clk(sys_clk), .rd_byte(rd_byte), .rd_byte_stb(rd_byte_stb),
      .blk_req(blk_req), .link_clk(link_clk), .link_sel_n(link_sel_n));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // Ceiling well above the longest scenario, so a hang still reaches the verdict
   initial begin
      wait (cycles >= 20000);
      fail_count++;
      give_verdict();
   end

   // ==========================================================
   // Reference model
   function automatic void predict();
      logic [1:0] et;
      logic [11:0] p;
      et = !scan_result.touch_end ? TFR_ET_RELEASE : scan_result.first ? TFR_ET_INITIAL : TFR_ET_MID;
      if (et == TFR_ET_MID && !scan_result.aperture_met) return;
      if (bq.size() == TFR_BLOCKS) begin
         ovf = 1;
         return;
      end
      for (int i = 0; i < nwords; i++) begin
         p = scan_result.pos[i];
         // 8-bit results without averaging carry four zero bits below them
         if (res8 != 0) p[3:0] = 4'h0;
         mq.push_back({p, 2'(i), et});
      end
      bq.push_back(nwords);
   endfunction

   function automatic logic [7:0] stat_exp();
      return {4'h0, touch_pin, 1'(bq.size() > 0), 1'(bq.size() == 0), 1'(ovf)};
   endfunction

   // ==========================================================
   // Measurement engine stand-in, answers a few cycles after a start
   always @(posedge sys_clk) begin
      st = scan_start;
      cycles++;
      if (st === 1'b1) starts++;
      #1;
      scan_done = 1'b0;
      if (st === 1'b1) begin
         eng_cnt = 4;
      end else if (eng_cnt > 0) begin
         eng_cnt--;
         if (eng_cnt == 0) begin
            scan_done = 1'b1;
            scan_result.pos = 48'({$random(seed), $random(seed)});
            scan_result.touch_end = touch_pin;
            scan_result.first = was_free;
            scan_result.aperture_met = 1'($random(seed));
            was_free = ~touch_pin;
            predict();
         end
      end
   end

   // ==========================================================
   // Checks and bus tasks
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      chk_byte(reg_rdata, exp);
      tick(1);
   endtask

   // Nothing stored reads back as one end-of-data word
   task automatic read_check();
      int n;
      logic [15:0] wd;
      n = (bq.size() > 0) ? bq.pop_front() : 1;
      tfr_host_model_inst.read_block(2 * n);
      chk_bit(touch_irq_out, 1'(bq.size() > 0));
      chk_byte(8'(tfr_host_model_inst.got_n), 8'(2 * n));
      for (int j = 0; j < n; j++) begin
         wd = (mq.size() > 0) ? mq.pop_front() : {12'h000, 2'b00, TFR_ET_EOF};
         chk_byte(tfr_host_model_inst.got[2 * j], wd[15:8]);
         chk_byte(tfr_host_model_inst.got[2 * j + 1], wd[7:0]);
      end
      for (int k = 0; k < 20 && blk_busy !== 1'b0; k++) tick(1);
      chk_bit(blk_busy, 1'b0);
   endtask

   task automatic scan_phase(input int t, input int hold, input bit clr);
      nwords = t + 1;
      res8 = (t == 3);
      // Passing through direct makes every phase a real mode change with its settle time
      reg_write(TFR_ADDR_MODE, 8'h01);
      reg_write(TFR_ADDR_MODE, 8'(2 + 4 * t + 16 * res8));
      mq.delete();
      bq.delete();
      ovf = 0;
      starts = 0;
      touch_pin = 1'b1;
      tick(TFR_SETTLE_CYC - 5);
      chk_byte(8'(starts), 8'h00);
      chk_bit(panel_drive_en, 1'b1);
      tick(hold);
      chk_bit(touch_irq_out, 1'(bq.size() > 0));
      touch_pin = 1'b0;
      tick(4 * INTERVAL);
      starts = 0;
      tick(10 * INTERVAL);
      chk_byte(8'(starts), 8'h00);
      reg_read(TFR_ADDR_STATUS, stat_exp());
      if (clr) begin
         if (bq.size() > 0) read_check();
         reg_write(TFR_ADDR_MODE, 8'h01);
         mq.delete();
         bq.delete();
         ovf = 0;
         tick(2);
         chk_bit(touch_irq_out, 1'b0);
         reg_read(TFR_ADDR_STATUS, stat_exp());
      end else begin
         while (bq.size() > 0) read_check();
         read_check();
      end
      $display("test scan type %0d done", t);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      reset = 1'b1;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      touch_pin = 1'b0;
      scan_done = 1'b0;
      scan_result = '0;
      was_free = 1'b1;
      repeat (16) @(posedge sys_clk);
      #1 reset = 1'b0;
      tick(1);
      chk_bit(panel_drive_en, 1'b0);
      reg_read(TFR_ADDR_STATUS, stat_exp());
      reg_read(8'h05, 8'h00);
      read_check();
      $display("test reset and empty read done");
      scan_phase(1, 400, 1'b0);
      scan_phase(2, 3000, 1'b0);
      scan_phase(3, 400, 1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
